// >>> design/tws_if.sv
// two-wire link between the master and the register-port slave
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // open-drain wire with pull-up: any enabled driver with a low output pulls low
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (output scl, input sda, output sda_m_o, output sda_m_oe);
endinterface
`default_nettype wire

// >>> design/tws_master.sv
// master end: makes the link clock from clk_i and runs single-register transfers
`timescale 1ns/1ps
`default_nettype none
module tws_master (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tws_if.master link,
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic [7:0] ptr_i,
  input wire logic [7:0] wdata_i,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o
);
  typedef struct packed {
    tws_pkg::tws_mst_t st;
    logic [7:0] div;
    logic ph;
    logic scl;
    logic sda;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh;
    logic rd;
    logic nack;
    logic [7:0] rdat;
    logic [1:0] s1;
    logic sd;
  } tws_m_t;
  tws_m_t q, d;
  // data changes half-way through the low phase
  localparam logic [7:0] MID_DIV = tws_pkg::TWS_HALF_DIV >> 1;
  function automatic logic [7:0] tws_byte(input logic [1:0] n, input logic rd, input logic [7:0] p,
                                          input logic [7:0] w);
    logic [7:0] r;
    r = w;
    if (n == 2'h0)
      r = tws_pkg::TWS_ADDR_WR;
    else if (n == 2'h1)
      r = p;
    else if (rd)
      r = tws_pkg::TWS_ADDR_RD;
    return r;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // phase ticks: each tick is one half of scl; data bits move sda in low phase, start and stop move it with scl high
  always_comb
  begin
    d = q;
    d.s1 = {q.s1[0], link.sda};
    d.sd = q.s1[1];
    done_o = 1'b0;
    d.div = q.div + 8'h1;
    if (q.st == tws_pkg::TWS_M_IDLE)
    begin
      d.div = tws_pkg::TWS_DIV_ZERO;
      if (req_i)
      begin
        d.st = tws_pkg::TWS_M_START;
        d.rd = rd_i;
        d.byten = 2'h0;
        d.nack = 1'b0;
      end
    end
    else if (q.st == tws_pkg::TWS_M_DONE)
    begin
      done_o = 1'b1;
      d.st = tws_pkg::TWS_M_IDLE;
    end
    else if (q.div == MID_DIV && !q.scl)
    begin
      // in the low phase sda moves only mid-way through it, never at an scl edge
      unique case (q.st)
        tws_pkg::TWS_M_BIT:
          d.sda = (q.rd && q.byten == 2'h3) ? 1'b1 : q.sh[7];
        tws_pkg::TWS_M_ACK, tws_pkg::TWS_M_RSTART:
          d.sda = 1'b1;
        tws_pkg::TWS_M_STOP0:
          d.sda = 1'b0;
        default: d.sda = q.sda;
      endcase
    end
    else if (q.div == tws_pkg::TWS_HALF_DIV)
    begin
      d.div = tws_pkg::TWS_DIV_ZERO;
      unique case (q.st)
        tws_pkg::TWS_M_START:
          if (!q.ph)
          begin
            d.sda = 1'b0;
            d.ph = 1'b1;
          end
          else
          begin
            d.scl = 1'b0;
            d.ph = 1'b0;
            d.st = tws_pkg::TWS_M_BIT;
            d.bitn = tws_pkg::TWS_BIT_ZERO;
            d.sh = tws_byte(q.byten, q.rd, ptr_i, wdata_i);
          end
        tws_pkg::TWS_M_RSTART:
          if (!q.scl)
            d.scl = 1'b1;
          else
          begin
            d.sda = 1'b0;
            d.ph = 1'b1;
            d.st = tws_pkg::TWS_M_START;
          end
        tws_pkg::TWS_M_BIT:
          if (!q.scl)
            d.scl = 1'b1;
          else
          begin
            // sample at the end of the high phase, when the line has long settled
            d.scl = 1'b0;
            d.sh = {q.sh[6:0], q.sd};
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == tws_pkg::TWS_BIT_LAST)
              d.st = tws_pkg::TWS_M_ACK;
          end
        tws_pkg::TWS_M_ACK:
          if (!q.scl)
            d.scl = 1'b1;
          else
          begin
            d.scl = 1'b0;
            if (q.rd && q.byten == 2'h3)
              d.rdat = q.sh;
            else if (q.sd)
              d.nack = 1'b1;
            d.byten = q.byten + 2'h1;
            d.bitn = tws_pkg::TWS_BIT_ZERO;
            d.sh = tws_byte(q.byten + 2'h1, q.rd, ptr_i, wdata_i);
            if (d.nack || q.byten == 2'h3 || (!q.rd && q.byten == 2'h2))
              d.st = tws_pkg::TWS_M_STOP0;
            else if (q.rd && q.byten == 2'h1)
              d.st = tws_pkg::TWS_M_RSTART;
            else
              d.st = tws_pkg::TWS_M_BIT;
          end
        tws_pkg::TWS_M_STOP0:
          begin
            d.scl = 1'b1;
            d.st = tws_pkg::TWS_M_STOP1;
          end
        tws_pkg::TWS_M_STOP1:
          begin
            d.sda = 1'b1;
            d.st = tws_pkg::TWS_M_DONE;
          end
        default: d.st = tws_pkg::TWS_M_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '{st: tws_pkg::TWS_M_IDLE, scl: 1'b1, sda: 1'b1, s1: 2'h3, sd: 1'b1, default: '0};
    else
      q <= d;
  end
  // sda is open drain, only a low is driven; scl is driven both high and low
  assign link.scl = q.scl;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !q.sda;
  assign nack_o = q.nack;
  assign rdata_o = q.rdat;
endmodule
`default_nettype wire

// >>> design/tws_pkg.sv
// shared constants and types for the two-wire register port
package tws_pkg;
  localparam logic [6:0] TWS_SLAVE_ADDR = 7'h59;
  localparam logic [7:0] TWS_ADDR_WR = 8'hb2;
  localparam logic [7:0] TWS_ADDR_RD = 8'hb3;
  localparam int unsigned TWS_BYTE_BITS = 8;
  localparam logic [3:0] TWS_BIT_LAST = 4'h7;
  localparam logic [3:0] TWS_BIT_ZERO = 4'h0;
  localparam logic [7:0] TWS_BYTE_ZERO = 8'h00;
  localparam int unsigned TWS_NUM_REGS = 256;
  // master divider: last count of each half period of the driven link clock; a half period is this plus one clk_i cycles
  localparam logic [7:0] TWS_HALF_DIV = 8'h7c;
  localparam logic [7:0] TWS_DIV_ZERO = 8'h00;
  typedef enum logic [1:0] {TWS_SES_IDLE, TWS_SES_ADDR, TWS_SES_WR, TWS_SES_RD} tws_ses_t;
  typedef enum logic [3:0] {
    TWS_M_IDLE, TWS_M_START, TWS_M_BIT, TWS_M_ACK, TWS_M_RSTART, TWS_M_STOP0, TWS_M_STOP1, TWS_M_DONE
  } tws_mst_t;
endpackage

// >>> design/tws_slave.sv
// register-port slave end, clocked by the link clock
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - data changes only while clock low
// - data fall with clock high starts
// - data rise with clock high stops
// - only master makes start and stop
// - bus busy from start to stop
// - repeated start acts like first start
// - eight bits per byte, msb first
// - ninth pulse: receiver pulls acknowledge low; the master leaves it high after the read byte
// - addressed slave acknowledges every received byte
// - address 59h in bits 7 to 1
// - direction 0 write, 1 read
// - write: pointer byte, then data byte
// - write commits at final ack rise
// - master writes pointer before reading
module tws_slave (
  input wire logic scl_i,
  input wire logic rst_n_i,
  tws_if.slave link,
  input wire logic clk_i,
  output logic busy_o,
  output logic [7:0] wr_ptr_o,
  output logic [7:0] wr_data_o,
  output logic wr_tgl_o
);
  typedef struct packed {
    tws_pkg::tws_ses_t ses;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic ack;
    logic ptr_ok;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic drv;
    logic dbit;
    logic wtgl;
    logic [7:0] wptr;
    logic [7:0] wdat;
    logic stseen;
  } tws_s_t;
  tws_s_t q, d;
  logic [7:0] regs_q [tws_pkg::TWS_NUM_REGS];
  logic st_tgl_q, sp_tgl_q, st_mark_q;
  logic [2:0] sync_q;
  logic [7:0] ptr_sync_q, dat_sync_q;
  logic commit;
  //////////////////////////////////////////////////////////////////////////////
  // start detector: a toggle, so the scl side sees every start, repeated ones too
  always_ff @(negedge link.sda or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_tgl_q <= 1'b0;
      st_mark_q <= 1'b1;
    end
    else if (scl_i)
    begin
      st_tgl_q <= ~st_tgl_q;
      st_mark_q <= sp_tgl_q;
    end
  end
  // stop detector: toggles; busy while the last start saw the current stop count
  always_ff @(posedge link.sda or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sp_tgl_q <= 1'b0;
    else if (scl_i)
      sp_tgl_q <= ~sp_tgl_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  // bit engine sampled on scl rise; start restarts the frame
  always_comb
  begin
    d = q;
    commit = 1'b0;
    if (st_tgl_q != q.stseen)
    begin
      d.stseen = st_tgl_q;
      d.ses = tws_pkg::TWS_SES_ADDR;
      d.bitn = tws_pkg::TWS_BIT_ZERO;
      d.ack = 1'b0;
      d.ptr_ok = 1'b0;
    end
    if (d.ses != tws_pkg::TWS_SES_IDLE)
    begin
      if (!d.ack)
      begin
        d.sh = {d.sh[6:0], link.sda};
        if (d.bitn == tws_pkg::TWS_BIT_LAST)
        begin
          d.ack = 1'b1;
          d.bitn = tws_pkg::TWS_BIT_ZERO;
        end
        else
          d.bitn = d.bitn + 4'h1;
      end
      else
      begin
        d.ack = 1'b0;
        unique case (d.ses)
          tws_pkg::TWS_SES_ADDR:
          begin
            if (d.sh[7:1] != tws_pkg::TWS_SLAVE_ADDR)
              d.ses = tws_pkg::TWS_SES_IDLE;
            else if (d.sh[0])
            begin
              d.ses = tws_pkg::TWS_SES_RD;
              d.tx = regs_q[q.ptr];
            end
            else
              d.ses = tws_pkg::TWS_SES_WR;
          end
          tws_pkg::TWS_SES_WR:
          begin
            if (!d.ptr_ok)
            begin
              d.ptr = d.sh;
              d.ptr_ok = 1'b1;
            end
            else
            begin
              commit = 1'b1;
              d.wptr = d.ptr;
              d.wdat = d.sh;
              d.wtgl = ~q.wtgl;
            end
          end
          tws_pkg::TWS_SES_RD:
            d.ses = tws_pkg::TWS_SES_IDLE;
          default: d.ses = tws_pkg::TWS_SES_IDLE;
        endcase
      end
    end
  end
  // register file write lands on the final acknowledge rise
  always_ff @(posedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end
  always_ff @(posedge scl_i)
  begin
    if (commit)
      regs_q[q.ptr] <= q.sh;
  end
  //////////////////////////////////////////////////////////////////////////////
  // drive sda on scl fall only, so it is steady while scl high
  logic [2:0] nbit;
  always_comb
  begin
    nbit = 3'(tws_pkg::TWS_BIT_LAST - q.bitn);
  end
  always_ff @(negedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.sda_s_oe <= 1'b0;
      link.sda_s_o <= 1'b1;
    end
    else if (q.ses == tws_pkg::TWS_SES_RD && !q.ack)
    begin
      link.sda_s_oe <= !q.tx[nbit];
      link.sda_s_o <= 1'b0;
    end
    else
    begin
      link.sda_s_oe <= q.ack && q.ses != tws_pkg::TWS_SES_IDLE && q.ses != tws_pkg::TWS_SES_RD &&
        (q.ses != tws_pkg::TWS_SES_ADDR || q.sh[7:1] == tws_pkg::TWS_SLAVE_ADDR);
      link.sda_s_o <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // write event crosses to clk_i by toggle; data stable since toggle flipped
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_q <= 3'h0;
      ptr_sync_q <= tws_pkg::TWS_BYTE_ZERO;
      dat_sync_q <= tws_pkg::TWS_BYTE_ZERO;
    end
    else
    begin
      sync_q <= {sync_q[1:0], q.wtgl};
      if (sync_q[2] != sync_q[1])
      begin
        ptr_sync_q <= q.wptr;
        dat_sync_q <= q.wdat;
      end
    end
  end
  assign wr_tgl_o = sync_q[2];
  assign wr_ptr_o = ptr_sync_q;
  assign wr_data_o = dat_sync_q;
  assign busy_o = (st_mark_q == sp_tgl_q);
endmodule
`default_nettype wire

// >>> verification/i2c_slave_register_port_tb.sv
// self-checking bench: master and slave ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_port_tb;
  logic clk_i, rst_n_i, req_i, rd_i, done_o, nack_o, busy_o, wr_tgl_o;
  logic [7:0] ptr_i, wdata_i, rdata_o, wr_ptr_o, wr_data_o;
  int n_fail = 0;
  int tests_run = 0;
  tws_if link();
  tws_master tws_master_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .req_i(req_i), .rd_i(rd_i),
    .ptr_i(ptr_i), .wdata_i(wdata_i), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
  tws_slave tws_slave_inst (.scl_i(link.scl), .rst_n_i(rst_n_i), .link(link), .clk_i(clk_i),
    .busy_o(busy_o), .wr_ptr_o(wr_ptr_o), .wr_data_o(wr_data_o), .wr_tgl_o(wr_tgl_o));
  tws_checker tws_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl(link.scl), .sda(link.sda),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one request; req drops after one edge so it is not taken twice
  task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] dat);
    int n;
    logic tgl;
    n = 0;
    tgl = wr_tgl_o;
    @(negedge clk_i);
    rd_i = rd;
    ptr_i = ptr;
    wdata_i = dat;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    repeat (1000) @(negedge clk_i);
    chk(8'h01, {7'h00, busy_o});
    chk({7'h00, tgl}, {7'h00, wr_tgl_o});
    while (done_o !== 1'b1 && n < 30000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(8'h01, {7'h00, done_o});
  endtask
  // write, then the committed pair and exactly one toggle
  task automatic test_write(input logic [7:0] ptr, input logic [7:0] dat);
    logic tgl;
    tgl = wr_tgl_o;
    xfer(1'b0, ptr, dat);
    repeat (4) @(negedge clk_i);
    chk(8'h00, {7'h00, nack_o});
    chk(8'h00, {7'h00, busy_o});
    chk(ptr, wr_ptr_o);
    chk(dat, wr_data_o);
    chk({7'h00, !tgl}, {7'h00, wr_tgl_o});
  endtask
  // pointer write, repeated start, one byte back; a pointer alone commits nothing
  task automatic test_read(input logic [7:0] ptr, input logic [7:0] exp);
    logic tgl;
    tgl = wr_tgl_o;
    xfer(1'b1, ptr, 8'h00);
    repeat (4) @(negedge clk_i);
    chk(exp, rdata_o);
    chk({7'h00, tgl}, {7'h00, wr_tgl_o});
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // five frames take about 42k cycles; allow 100k, over double
  initial
  begin
    #1000000;
    n_fail++;
    finish_test();
  end
  // bit-asymmetric values, except pointer ff, so a reversed bit order shows up
  initial
  begin
    rst_n_i = 1'b0;
    req_i = 1'b0;
    rd_i = 1'b0;
    ptr_i = 8'h00;
    wdata_i = 8'h00;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    test_write(8'h03, 8'hc1);
    test_write(8'hff, 8'h1e);
    test_read(8'hff, 8'h1e);
    test_read(8'h03, 8'hc1);
    test_write(8'h03, 8'h80);
    finish_test();
  end
endmodule
`default_nettype wire

// >>> verification/tws_checker.sv
// link protocol checker between master and register-port slave
`timescale 1ns/1ps
`default_nettype none
module tws_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, rd_q, hit_q;
  logic [3:0] cnt_q;
  logic [2:0] nby_q;
  logic [6:0] sh_q;
  wire logic s_low = sda_s_oe && !sda_s_o;
  wire logic m_low = sda_m_oe && !sda_m_o;
  wire logic rise = scl && !scl_q;
  wire logic ack9 = rise && cnt_q == 4'h8;
  ////////////////////////////////////////////////////////////////////////////////
  // oversample the link; start/stop can only sit at count 0 or 1, so later counts must hold still
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      cnt_q <= 4'h0;
      nby_q <= 3'h0;
      sh_q <= 7'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        cnt_q <= 4'h0;
        nby_q <= 3'h0;
        rd_q <= 1'b0;
      end
      else if (rise)
      begin
        cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
        sh_q <= {sh_q[5:0], sda};
        if (cnt_q == 4'h9)
          nby_q <= nby_q + 3'h1;
        if (cnt_q == 4'h7 && nby_q == 3'h0)
        begin
          hit_q <= (sh_q == tws_pkg::TWS_SLAVE_ADDR);
          rd_q <= sda;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one domain only, so one clocking and one disable
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  slave_drive_hold_a: assert property ($changed(s_low) |-> !scl)
    else $error("slave drive moved with clock high");
  start_by_master_a: assert property (scl && $past(scl) && $fell(sda) |-> m_low && !s_low)
    else $error("start not made by master");
  stop_by_master_a: assert property (scl && $past(scl) && $rose(sda) |-> $past(m_low))
    else $error("stop not made by master");
  data_stable_a: assert property (scl && $past(scl) && cnt_q >= 4'h2 |-> $stable(sda))
    else $error("data moved inside a byte");
  addr_ack_a: assert property (ack9 && nby_q == 3'h0 && hit_q |-> s_low)
    else $error("own address not acknowledged");
  write_ack_a: assert property (ack9 && nby_q != 3'h0 && !rd_q |-> s_low && !m_low)
    else $error("written byte not acknowledged");
  read_release_a: assert property (ack9 && nby_q != 3'h0 && rd_q |-> !s_low)
    else $error("slave held line in master ack slot");
  read_only_drive_a: assert property (s_low && cnt_q >= 4'h1 && cnt_q <= 4'h7 |-> rd_q && nby_q != 3'h0)
    else $error("slave drove data outside a read");
endmodule
`default_nettype wire
